// *** rtl/sysp_pkg.sv ***
package sysp_pkg;
    // Device register offsets
    localparam logic [7:0]  OFS_CHIP_IDENT = 8'h00;
    localparam logic [7:0]  OFS_PIN_CFG    = 8'h04;
    // Identification value; upper bytes are arbitrary
    localparam logic [23:0] IDENT_BASE     = 24'h5a3ce1;
    localparam logic [7:0]  IDENT_REV      = 8'h01;
    // Pin configuration reset value and writable bits
    localparam logic [31:0] PIN_CFG_RST    = 32'hffff_0304;
    localparam logic [31:0] PIN_CFG_RW     = 32'hffff_930f;
    localparam logic [31:0] HALF_MASK      = 32'h0000_ffff;
    localparam logic        ACK_LVL_RST    = 1'h0;
    // Pin configuration field positions
    localparam int IRQ0_SEL_LSB = 24;
    localparam int PORT_A_LSB   = 20;
    localparam int PORT_B_LSB   = 16;
    localparam int ISO_OFF_BIT  = 15;
    localparam int CONT_BIT     = 12;
    localparam int IRQ_FLT_BIT  = 9;
    localparam int ACK_FLT_BIT  = 8;
    localparam int ACK_LVL_WR   = 5;
    localparam int ACK_LVL_RD   = 4;
    localparam int STRB_LVL_BIT = 3;
    localparam int DIR_LVL_BIT  = 2;
    localparam int SEL_LVL_BIT  = 1;
    localparam int SIZE_LVL_BIT = 0;
    // General-purpose pin interrupt sources
    localparam int         GPIO_N       = 10;
    localparam logic [3:0] GPIO_SRC_MAX = 4'h9;
    // Host controller register offsets
    localparam logic [7:0] H_OFS_LEVELS   = 8'h00;
    localparam logic [7:0] H_OFS_ADDR     = 8'h04;
    localparam logic [7:0] H_OFS_WDATA    = 8'h08;
    localparam logic [7:0] H_OFS_CMD      = 8'h0c;
    localparam logic [7:0] H_OFS_RDATA    = 8'h10;
    localparam logic [7:0] H_OFS_BUSY     = 8'h14;
    localparam logic [7:0] H_OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] H_OFS_IRQ_CLR  = 8'h1c;
    localparam logic [7:0] H_OFS_IRQ_EN   = 8'h20;
    // Host levels: 0 size, 1 select, 2 dir, 3 strobe, 4 ack
    localparam logic [4:0] H_LEVELS_RST   = 5'h04;
    localparam int CMD_GO_BIT   = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int CMD_WIDE_BIT = 2;
    localparam int EV_DONE      = 0;
    localparam int EV_DEV_IRQ   = 1;
    // Host transfer states
    typedef enum logic [3:0] {
        H_IDLE  = 4'b0001,
        H_SETUP = 4'b0010,
        H_STRB  = 4'b0100,
        H_DONE  = 4'b1000
    } sysp_hstate_t;
endpackage

// *** rtl/sysp_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sysp_link_if #(parameter int AW = 8);
    // Host-driven pins, raw levels
    logic          select_pin;
    logic          strobe_pin;
    logic          dir_pin;
    logic          size_pin;
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          ack_pull;
    // Device-driven pins
    logic [31:0]   rdata;
    logic          ack_drv;
    logic          ack_oe;
    logic          irq_drv;
    logic          irq_oe;
    // Resolved wires; released pins sit at the pull level
    logic          ack_pin;
    logic          irq_pin;
    assign ack_pin = ack_oe ? ack_drv : ack_pull;
    assign irq_pin = irq_oe ? irq_drv : 1'h1;
    modport device (
        input  select_pin, strobe_pin, dir_pin, size_pin, addr, wdata,
        output rdata, ack_drv, ack_oe, irq_drv, irq_oe
    );
    modport host (
        output select_pin, strobe_pin, dir_pin, size_pin, addr, wdata,
        output ack_pull,
        input  rdata, ack_pin, irq_pin
    );
endinterface
`default_nettype wire

// *** rtl/sysp_level.sv ***
`timescale 1ns/1ps
`default_nettype none
// Maps active state to pin level and back; the map is its own inverse
module sysp_level #(parameter int W = 1) (
    // Value and programmed active levels
    input  wire logic [W-1:0] a_i,
    input  wire logic [W-1:0] level_i,
    // Converted value
    output logic      [W-1:0] y_o
);
    // Level 1 passes the value, level 0 inverts it
    assign y_o = ~(a_i ^ level_i);
endmodule
`default_nettype wire

// *** rtl/sysp_device.sv ***
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module sysp_device #(
    parameter int         AW  = 8,
    parameter logic [7:0] REV = sysp_pkg::IDENT_REV
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Microcontroller link
    sysp_link_if.device                     link,
    // General-purpose pins and their interrupts
    input  wire logic [sysp_pkg::GPIO_N-1:0] gpio_i,
    output logic      [1:0]                 gpio_irq_o,
    // Interrupt request from the core
    input  wire logic                       irq_req_i,
    // Data port active levels
    output logic      [3:0]                 port_a_level_o,
    output logic      [3:0]                 port_b_level_o,
    // PHY link pins
    output logic                            bus_holder_isolation_off_o,
    input  wire logic                       contender_d_i,
    input  wire logic                       contender_pin_i,
    output logic                            contender_pin_o,
    output logic                            contender_pin_oe_o,
    output logic                            contender_rx_o
);
    import sysp_pkg::*;

    logic [31:0] cfg_r;
    logic        ack_lvl_r;
    logic        ack_lvl_nxt;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic        irq_drv_r;
    logic        irq_oe_r;
    logic [1:0]  gpio_irq_r;
    logic        cont_q_r;
    logic        cont_rx_r;
    logic        sel_act;
    logic        stb_act;
    logic        rd_act;
    logic        wide_act;
    logic        take;
    logic        hit_ident;
    logic        hit_cfg;
    logic [31:0] wmask;
    logic [31:0] rd_val;
    logic [31:0] ident;

    // Host pins decoded through the programmed levels
    sysp_level #(.W(4)) u_in_level (
        .a_i     ({link.select_pin, link.strobe_pin,
                   link.dir_pin, link.size_pin}),
        .level_i ({cfg_r[SEL_LVL_BIT], cfg_r[STRB_LVL_BIT],
                   cfg_r[DIR_LVL_BIT], cfg_r[SIZE_LVL_BIT]}),
        .y_o     ({sel_act, stb_act, rd_act, wide_act})
    );

    // Ack pin level follows its own programmed level
    sysp_level #(.W(1)) u_ack_level (
        .a_i     (ack_r),
        .level_i (ack_lvl_r),
        .y_o     (link.ack_drv)
    );

    // A new access is taken only once the last ack is gone
    assign take = sel_act & stb_act & ~ack_r;

    // Address decode; anything else reads zero
    assign hit_ident = link.addr == AW'(OFS_CHIP_IDENT);
    assign hit_cfg   = link.addr == AW'(OFS_PIN_CFG);

    // Narrow writes reach the low half only
    assign wmask = wide_act ? 32'hffff_ffff : HALF_MASK;

    // Only the low byte carries the revision
    assign ident = {IDENT_BASE, REV};

    // Read value; reserved and write-only bits read zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (hit_ident) begin
            rd_val = ident;
        end else if (hit_cfg) begin
            rd_val = cfg_r & PIN_CFG_RW;
            rd_val[ACK_LVL_RD] = ack_lvl_r;
        end
    end

    // Configuration store; the ident word ignores writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= PIN_CFG_RST & PIN_CFG_RW;
        end else if (take && !rd_act && hit_cfg) begin
            cfg_r <= (cfg_r & ~(wmask & PIN_CFG_RW))
                   | (link.wdata & wmask & PIN_CFG_RW);
        end
    end

    // Ack level sits apart: written at one bit, read at another
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_lvl_nxt <= ACK_LVL_RST;
        end else if (take && !rd_act && hit_cfg) begin
            ack_lvl_nxt <= link.wdata[ACK_LVL_WR];
        end
    end

    // New ack level waits until the writing access has let go;
    // switching mid-answer would hide that ack and hang the host
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_lvl_r <= ACK_LVL_RST;
        end else if (!ack_r) begin
            ack_lvl_r <= ack_lvl_nxt;
        end
    end

    // Ack rises after the access and holds until strobe drops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'h0;
        end else if (take) begin
            ack_r <= 1'h1;
        end else if (!stb_act) begin
            ack_r <= 1'h0;
        end
    end

    // Read data is captured at the access and held after it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (take && rd_act) begin
            rdata_r <= rd_val;
        end
    end

    assign link.rdata = rdata_r;

    // Released ack sits at the host pull level, seen as inactive
    assign link.ack_oe = ~cfg_r[ACK_FLT_BIT] | ack_r;

    // Interrupt pin is low while asserted; float keeps it released
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_drv_r <= 1'h1;
            irq_oe_r  <= 1'h0;
        end else begin
            irq_drv_r <= ~irq_req_i;
            irq_oe_r  <= ~cfg_r[IRQ_FLT_BIT] | irq_req_i;
        end
    end

    assign link.irq_drv = irq_drv_r;
    assign link.irq_oe  = irq_oe_r;

    // One selector per GPIO interrupt; codes above nine pick none
    for (genvar c = 0; c < 2; c++) begin : g_gpio_irq
        logic [3:0] src;
        assign src = cfg_r[IRQ0_SEL_LSB + 4*c +: 4];
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                gpio_irq_r[c] <= 1'h0;
            end else if (src <= GPIO_SRC_MAX) begin
                gpio_irq_r[c] <= gpio_i[src];
            end else begin
                gpio_irq_r[c] <= 1'h0;
            end
        end
    end

    assign gpio_irq_o = gpio_irq_r;

    // Levels come straight from the store, live the cycle after a write
    assign port_a_level_o = cfg_r[PORT_A_LSB +: 4];
    assign port_b_level_o = cfg_r[PORT_B_LSB +: 4];
    assign bus_holder_isolation_off_o = cfg_r[ISO_OFF_BIT];

    // Contender direction; input sampling is masked while driving
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cont_q_r  <= 1'h0;
            cont_rx_r <= 1'h0;
        end else begin
            cont_q_r  <= contender_d_i;
            cont_rx_r <= cfg_r[CONT_BIT] ? 1'h0 : contender_pin_i;
        end
    end

    assign contender_pin_o    = cont_q_r;
    assign contender_pin_oe_o = cfg_r[CONT_BIT];
    assign contender_rx_o     = cont_rx_r;
endmodule
`default_nettype wire

// *** rtl/sysp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sysp_host #(parameter int AW = 8) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt
    output logic             irq_o,
    // Microcontroller link
    sysp_link_if.host        link
);
    import sysp_pkg::*;

    sysp_hstate_t  st_r;
    logic [4:0]    lvl_r;
    logic [AW-1:0] addr_r;
    logic [31:0]   wdata_r;
    logic [31:0]   rdata_r;
    logic          rd_r;
    logic          wide_r;
    logic [1:0]    stat_r;
    logic [1:0]    en_r;
    logic          ack_r;
    logic [31:0]   dat_r;
    logic          acc;
    logic          wr;
    logic [7:0]    ofs;
    logic [31:0]   bm;
    logic          ack_act;
    logic          sel_a;
    logic          stb_a;
    logic          go;
    logic          done_ev;
    logic [1:0]    ev;

    assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_r; // Lands with ack
    assign ofs = {wb_adr_i[7:2], 2'h0};
    assign bm  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign go  = wr & (ofs == H_OFS_CMD) & wb_sel_i[0]
               & wb_dat_i[CMD_GO_BIT] & (st_r == H_IDLE);

    // Link pins through the levels the device was given
    sysp_level #(.W(5)) u_pins (
        .a_i     ({1'h0, stb_a, rd_r, sel_a, wide_r}),
        .level_i (lvl_r),
        .y_o     ({link.ack_pull, link.strobe_pin, link.dir_pin,
                   link.select_pin, link.size_pin})
    );
    assign ack_act = ~(link.ack_pin ^ lvl_r[4]);
    assign sel_a   = st_r != H_IDLE;
    assign stb_a   = st_r == H_STRB;
    assign link.addr  = addr_r;
    assign link.wdata = wdata_r;

    // Bus answer one cycle after the request; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'h0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= acc;
            if (acc) begin
                unique case (ofs)
                    H_OFS_LEVELS:   dat_r <= {27'h0, lvl_r};
                    H_OFS_ADDR:     dat_r <= 32'(addr_r);
                    H_OFS_WDATA:    dat_r <= wdata_r;
                    H_OFS_RDATA:    dat_r <= rdata_r;
                    H_OFS_BUSY:     dat_r <= {31'h0, sel_a};
                    H_OFS_IRQ_STAT: dat_r <= {30'h0, stat_r};
                    H_OFS_IRQ_EN:   dat_r <= {30'h0, en_r};
                    default:        dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Link setup registers are frozen during a transfer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_r   <= H_LEVELS_RST;
            addr_r  <= '0;
            wdata_r <= 32'h0000_0000;
            en_r    <= 2'h0;
        end else if (wr) begin
            if (ofs == H_OFS_LEVELS && !sel_a && wb_sel_i[0])
                lvl_r <= wb_dat_i[4:0];
            if (ofs == H_OFS_ADDR && !sel_a)
                addr_r <= AW'((32'(addr_r) & ~bm) | (wb_dat_i & bm));
            if (ofs == H_OFS_WDATA && !sel_a)
                wdata_r <= (wdata_r & ~bm) | (wb_dat_i & bm);
            if (ofs == H_OFS_IRQ_EN && wb_sel_i[0])
                en_r <= wb_dat_i[1:0];
        end
    end

    // Transfer sequence: select, strobe, wait ack, release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r    <= H_IDLE;
            rd_r    <= 1'h0;
            wide_r  <= 1'h0;
            rdata_r <= 32'h0000_0000;
        end else begin
            unique case (st_r)
                H_IDLE: if (go) begin
                    rd_r   <= wb_dat_i[CMD_READ_BIT];
                    wide_r <= wb_dat_i[CMD_WIDE_BIT];
                    st_r   <= H_SETUP;
                end
                H_SETUP: st_r <= H_STRB;
                H_STRB: if (ack_act) begin
                    if (rd_r)
                        rdata_r <= link.rdata;
                    st_r <= H_DONE;
                end
                H_DONE: if (!ack_act) begin
                    st_r <= H_IDLE;
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end
    assign done_ev = (st_r == H_DONE) & ~ack_act;

    // Sticky events; a new event beats a clear in the same cycle
    assign ev = {~link.irq_pin, done_ev};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= 2'h0;
        end else if (wr && ofs == H_OFS_IRQ_CLR && wb_sel_i[0]) begin
            stat_r <= (stat_r & ~wb_dat_i[1:0]) | ev;
        end else begin
            stat_r <= stat_r | ev;
        end
    end
    assign irq_o = |(stat_r & en_r);
endmodule
`default_nettype wire

// *** test/sysp_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module sysp_chk #(parameter int AW = 8) (
    // Clock and reset
    input wire logic          clk_i,
    input wire logic          rst_i,
    // Host-driven pins
    input wire logic          select_pin,
    input wire logic          strobe_pin,
    input wire logic          dir_pin,
    input wire logic          size_pin,
    input wire logic [AW-1:0] addr,
    input wire logic [31:0]   wdata,
    input wire logic          ack_pull,
    // Device-driven pins
    input wire logic [31:0]   rdata,
    input wire logic          ack_drv,
    input wire logic          ack_oe,
    input wire logic          irq_drv,
    input wire logic          irq_oe,
    // Resolved wires
    input wire logic          ack_pin,
    input wire logic          irq_pin
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Ack counts as active when it differs from the released level
    logic ack_act;
    assign ack_act = (ack_pin != ack_pull);

    chk_ack_float: assert property (ack_oe |-> ack_drv != ack_pull)
        else $error("ack driven at its inactive level");
    chk_ack_driven: assert property (ack_act |-> ack_oe)
        else $error("ack active without its driver");
    chk_irq_float: assert property (irq_oe |-> !irq_drv)
        else $error("irq driven while not asserted");
    chk_irq_driven: assert property (!irq_drv |-> irq_oe)
        else $error("asserted irq left floating");
    chk_ack_hold: assert property (
        ack_act && $stable(strobe_pin) |=> ack_act)
        else $error("ack dropped before strobe released");
    chk_ack_drop: assert property (
        ack_act && $changed(strobe_pin) |=> !ack_act)
        else $error("ack kept after strobe released");
    chk_ack_shape: assert property ($rose(ack_act) |=> ack_act ##1 !ack_act)
        else $error("ack pulse not two cycles");
    chk_rdata_when: assert property ($changed(rdata) |-> $rose(ack_act))
        else $error("read data moved outside an answer");
    chk_req_stable: assert property ($rose(ack_act) |-> $stable(addr)
        && $stable(wdata) && $stable(dir_pin) && $stable(size_pin))
        else $error("request changed while taken");
    chk_select_hold: assert property (ack_act |-> $stable(select_pin))
        else $error("select moved during answer");
endmodule
`default_nettype wire

// *** test/system_pin_config_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module system_pin_config_regs_tb_top;
    import sysp_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, q, rdo;
    logic        ack, irq_o, irq_req = 1'b0, cont_d = 1'b0, cont_in = 1'b1;
    logic [9:0]  gpio = 10'h000;
    logic [1:0]  gpio_irq;
    logic [3:0]  pa, pb;
    logic        iso, c_o, c_oe, c_rx;
    int          num_errors = 0, cmp_count = 0, cycles = 0;

    always #4 clk_i = ~clk_i;

    sysp_link_if #(.AW(8)) u_link ();
    sysp_host #(.AW(8)) u_sysp_host (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
        .irq_o(irq_o), .link(u_link.host));
    sysp_device #(.AW(8)) u_sysp_device (.clk_i(clk_i), .rst_i(rst_i),
        .link(u_link.device), .gpio_i(gpio), .gpio_irq_o(gpio_irq),
        .irq_req_i(irq_req), .port_a_level_o(pa), .port_b_level_o(pb),
        .bus_holder_isolation_off_o(iso), .contender_d_i(cont_d),
        .contender_pin_i(cont_in), .contender_pin_o(c_o),
        .contender_pin_oe_o(c_oe), .contender_rx_o(c_rx));
    sysp_chk #(.AW(8)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
        .select_pin(u_link.select_pin), .strobe_pin(u_link.strobe_pin),
        .dir_pin(u_link.dir_pin), .size_pin(u_link.size_pin),
        .addr(u_link.addr), .wdata(u_link.wdata),
        .ack_pull(u_link.ack_pull), .rdata(u_link.rdata),
        .ack_drv(u_link.ack_drv), .ack_oe(u_link.ack_oe),
        .irq_drv(u_link.irq_drv), .irq_oe(u_link.irq_oe),
        .ack_pin(u_link.ack_pin), .irq_pin(u_link.irq_pin));

    task automatic test_done;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask

    // One classic cycle; the answer time is not assumed
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        // Outputs are read a cycle on, once the write has settled
        @(posedge clk_i);
    endtask

    // Link transfer through the host; leaves the read word in q
    task automatic lk(input logic [7:0] a, input logic [31:0] d,
                      input logic [2:0] cmd);
        wb(1'b1, H_OFS_ADDR, {24'h0, a});
        wb(1'b1, H_OFS_WDATA, d);
        wb(1'b1, H_OFS_CMD, {29'h0, cmd});
        wb(1'b0, H_OFS_BUSY, 32'h0);
        while (q[0] !== 1'b0) wb(1'b0, H_OFS_BUSY, 32'h0);
        wb(1'b0, H_OFS_RDATA, 32'h0);
    endtask

    // Hang guard: far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, H_OFS_LEVELS, 32'h0);
        chk(q, {27'h0, H_LEVELS_RST});
        lk(OFS_CHIP_IDENT, 32'h0, 3'b111);
        chk(q, {IDENT_BASE, IDENT_REV});
        lk(OFS_PIN_CFG, 32'h0, 3'b111);
        chk(q, 32'hffff_0304);
        chk({22'h0, pa, pb, iso, c_oe}, 32'h3fc);
        chk({30'h0, c_o, c_rx}, 32'h1);
        lk(OFS_CHIP_IDENT, 32'h0, 3'b101);
        lk(OFS_CHIP_IDENT, 32'h0, 3'b111);
        chk(q, {IDENT_BASE, IDENT_REV});
        // Reserved and read-only bits set; strobe and ack levels kept
        lk(OFS_PIN_CFG, 32'h96a5_ffd4, 3'b101);
        chk({22'h0, pa, pb, iso, c_oe}, 32'h297);
        lk(OFS_PIN_CFG, 32'h0, 3'b111);
        chk(q, 32'h96a5_9304);
        cont_d <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({30'h0, c_o, c_rx}, 32'h2);
        gpio <= 10'h200;
        repeat (2) @(posedge clk_i);
        chk({30'h0, gpio_irq}, 32'h2);
        gpio <= 10'h040;
        repeat (2) @(posedge clk_i);
        chk({30'h0, gpio_irq}, 32'h1);
        // Size inactive touches only the low half
        lk(OFS_PIN_CFG, 32'h0000_9305, 3'b001);
        wb(1'b1, H_OFS_LEVELS, 32'h5);
        lk(OFS_PIN_CFG, 32'h0, 3'b111);
        chk(q, 32'h96a5_9305);
        lk(OFS_PIN_CFG, 32'hfa00_9305, 3'b101);
        lk(OFS_PIN_CFG, 32'h0, 3'b111);
        chk(q, 32'hfa00_9305);
        gpio <= 10'h3ff;
        repeat (2) @(posedge clk_i);
        chk({30'h0, gpio_irq}, 32'h0);
        // Inverted read/write encoding on both ends
        lk(OFS_PIN_CFG, 32'hfa00_9301, 3'b101);
        wb(1'b1, H_OFS_LEVELS, 32'h1);
        lk(OFS_PIN_CFG, 32'h0, 3'b111);
        chk(q, 32'hfa00_9301);
        // Ack level flipped to active high on both ends
        lk(OFS_PIN_CFG, 32'hfa00_9321, 3'b101);
        wb(1'b1, H_OFS_LEVELS, 32'h11);
        lk(OFS_PIN_CFG, 32'h0, 3'b111);
        chk(q, 32'hfa00_9311);
        lk(8'h08, 32'h0, 3'b111);
        chk(q, 32'h0);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        // Interrupt: raise, mask, clear
        wb(1'b1, H_OFS_IRQ_CLR, 32'h3);
        wb(1'b1, H_OFS_IRQ_EN, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        lk(OFS_CHIP_IDENT, 32'h0, 3'b111);
        chk({31'h0, irq_o}, 32'h1);
        wb(1'b1, H_OFS_IRQ_EN, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        wb(1'b0, H_OFS_IRQ_STAT, 32'h0);
        chk(q, 32'h1);
        wb(1'b1, H_OFS_IRQ_CLR, 32'h3);
        wb(1'b1, H_OFS_IRQ_EN, 32'h2);
        irq_req <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({30'h0, u_link.irq_pin, irq_o}, 32'h1);
        irq_req <= 1'b0;
        repeat (3) @(posedge clk_i);
        wb(1'b1, H_OFS_IRQ_CLR, 32'h3);
        chk({30'h0, u_link.irq_pin, irq_o}, 32'h2);
        test_done();
    end
endmodule
`default_nettype wire
